// file: logic/power_control_pwm_time_base.sv
// Power-control PWM: time base, postscaler, duty generators and output pairs.
// Assumes all control inputs come from logic on the same clock.
`timescale 1ns/1ps
module power_control_pwm_time_base
  import pwm_time_base_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic               time_base_enable,
  input  wire logic [1:0]         time_base_mode_sel,
  input  wire logic [POST_W-1:0]  time_base_post_div_sel,
  input  wire logic [1:0]         time_base_pre_div_sel,
  input  wire logic               time_base_control_wr,
  input  wire logic               time_base_count_wr,
  input  wire logic [CNT_W-1:0]   time_base_count_wdata,
  input  wire logic [CNT_W-1:0]   time_base_period,
  input  wire logic [CNT_W-1:0]   duty_0,
  input  wire logic [CNT_W-1:0]   duty_1,
  input  wire logic [CNT_W-1:0]   duty_2,
  input  wire logic [CNT_W-1:0]   duty_3,
  input  wire logic [NUM_GEN-1:0] complementary,
  input  wire logic [DT_W-1:0]    dead_time,
  input  wire logic [NUM_OUT-1:0] override_enable,
  input  wire logic [NUM_OUT-1:0] override_value,
  input  wire logic [CNT_W-1:0]   special_event_compare,
  input  wire logic               debug_mode,
  input  wire logic               debug_disable_enable,
  output logic [NUM_OUT-1:0]      pwm_out_r,
  output logic                    time_base_irq_r,
  output logic                    special_trigger_r,
  output logic [CNT_W-1:0]        time_base_count_r,
  output logic                    count_direction_flag_r,
  output logic                    single_pulse_done_r
);

  // Last prescaler count for a ratio select
  function automatic logic [PRE_W-1:0] pre_last(input logic [1:0] sel);
    case (sel)
      PRE_DIV_1:  pre_last = PRE_LAST_1;
      PRE_DIV_4:  pre_last = PRE_LAST_4;
      PRE_DIV_16: pre_last = PRE_LAST_16;
      default:    pre_last = PRE_LAST_64;
    endcase
  endfunction

  // Center-aligned modes count up and down
  function automatic logic is_center(input logic [1:0] mode);
    is_center = (mode == MODE_UPDOWN) || (mode == MODE_UPDOWN_DBL);
  endfunction

  run_state_type     state_r;
  logic [PRE_W-1:0]  pre_cnt_r;
  logic [POST_W-1:0] post_cnt_r;
  logic [CNT_W-1:0]  period_r;
  logic [CNT_W-1:0]  duty_sh_r [NUM_GEN];
  logic [CNT_W-1:0]  duty_in   [NUM_GEN];
  logic [NUM_GEN-1:0] raw_r;
  logic [NUM_OUT-1:0] pair_out;

  logic running;
  logic tick;
  logic center;
  logic at_top;
  logic at_bottom;
  logic top_evt;
  logic bottom_evt;
  logic edge_match;
  logic boundary;
  logic tb_evt;
  logic post_hit;
  logic debug_kill;

  assign duty_in[0] = duty_0;
  assign duty_in[1] = duty_1;
  assign duty_in[2] = duty_2;
  assign duty_in[3] = duty_3;

  assign running    = (state_r == ST_RUN);
  assign center     = is_center(time_base_mode_sel);
  assign tick       = running && (pre_cnt_r == pre_last(time_base_pre_div_sel));
  // At-or-above keeps a shrunk period from running the count past it
  assign at_top     = (time_base_count_r >= period_r);
  assign at_bottom  = (time_base_count_r == COUNT_RST);
  assign edge_match = tick && !center && at_top;
  assign top_evt    = tick && center && !count_direction_flag_r && at_top;
  assign bottom_evt = tick && center && count_direction_flag_r && at_bottom;
  assign boundary   = edge_match || bottom_evt || !running;
  assign post_hit   = (post_cnt_r == time_base_post_div_sel);
  assign debug_kill = debug_mode && debug_disable_enable;

  // Interrupt event source chosen by mode
  always_comb begin
    case (time_base_mode_sel)
      MODE_FREE:       tb_evt = edge_match;
      MODE_SINGLE:     tb_evt = edge_match;
      MODE_UPDOWN:     tb_evt = bottom_evt;
      MODE_UPDOWN_DBL: tb_evt = bottom_evt || top_evt;
      default:         tb_evt = 1'b0;
    endcase
  end

  // Run control; single-pulse mode stops after one period
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (time_base_enable) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!time_base_enable) begin
            state_r <= ST_IDLE;
          end else if (time_base_mode_sel == MODE_SINGLE && edge_match) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (!time_base_enable || time_base_control_wr) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      single_pulse_done_r <= 1'b0;
    end else if (ce) begin
      single_pulse_done_r <= (state_r == ST_DONE);
    end
  end

  // Input prescaler
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt_r <= PRE_RST;
    end else if (ce) begin
      if (!running || time_base_count_wr || tick) begin
        pre_cnt_r <= PRE_RST;
      end else begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
    end
  end

  // Time-base counter; a control write does not touch it
  always_ff @(posedge clock) begin
    if (rst) begin
      time_base_count_r      <= COUNT_RST;
      count_direction_flag_r <= 1'b0;
    end else if (ce) begin
      if (time_base_count_wr) begin
        time_base_count_r <= time_base_count_wdata;
      end else if (tick) begin
        if (!center) begin
          if (at_top) begin
            time_base_count_r <= COUNT_RST;
          end else begin
            time_base_count_r <= time_base_count_r + 12'h001;
          end
          count_direction_flag_r <= 1'b0;
        end else if (!count_direction_flag_r) begin
          if (at_top && period_r != COUNT_RST) begin
            count_direction_flag_r <= 1'b1;
            time_base_count_r      <= time_base_count_r - 12'h001;
          end else if (!at_top) begin
            time_base_count_r <= time_base_count_r + 12'h001;
          end
        end else begin
          if (at_bottom) begin
            count_direction_flag_r <= 1'b0;
            time_base_count_r      <= time_base_count_r + 12'h001;
          end else begin
            time_base_count_r <= time_base_count_r - 12'h001;
          end
        end
      end
    end
  end

  // Period and duty shadows reload at a period boundary and on every cycle while the time base is not running
  always_ff @(posedge clock) begin
    if (rst) begin
      period_r <= PERIOD_RST;
    end else if (ce && boundary) begin
      period_r <= time_base_period;
    end
  end

  // Postscaler: counts interrupt events
  always_ff @(posedge clock) begin
    if (rst) begin
      post_cnt_r <= POST_RST;
    end else if (ce) begin
      if (time_base_count_wr || time_base_control_wr) begin
        post_cnt_r <= POST_RST;
      end else if (tb_evt) begin
        if (post_hit) begin
          post_cnt_r <= POST_RST;
        end else begin
          post_cnt_r <= post_cnt_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      time_base_irq_r <= 1'b0;
    end else if (ce) begin
      // Clearing writes win: the count restarts before it can reach the ratio
      time_base_irq_r <= tb_evt && post_hit && !time_base_count_wr
                         && !time_base_control_wr;
    end else begin
      time_base_irq_r <= 1'b0;
    end
  end

  // Special-event trigger
  always_ff @(posedge clock) begin
    if (rst) begin
      special_trigger_r <= 1'b0;
    end else if (ce) begin
      special_trigger_r <= tick && (time_base_count_r == special_event_compare);
    end else begin
      special_trigger_r <= 1'b0;
    end
  end

  // Duty generators and their output pairs
  generate
    for (genvar g = 0; g < NUM_GEN; g++) begin : gen_duty
      always_ff @(posedge clock) begin
        if (rst) begin
          duty_sh_r[g] <= DUTY_RST;
        end else if (ce && boundary) begin
          duty_sh_r[g] <= duty_in[g];
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          raw_r[g] <= 1'b0;
        end else if (ce) begin
          if (!running) begin
            raw_r[g] <= 1'b0;
          end else if (duty_sh_r[g] == DUTY_RST) begin
            raw_r[g] <= 1'b0;
          end else if (duty_sh_r[g] >= period_r) begin
            raw_r[g] <= 1'b1;
          end else if (center) begin
            if (time_base_count_r == duty_sh_r[g]) begin
              raw_r[g] <= count_direction_flag_r;
            end
          end else if (tick) begin
            if (at_top) begin
              raw_r[g] <= 1'b1;
            end else if (time_base_count_r + 12'h001 == duty_sh_r[g]) begin
              raw_r[g] <= 1'b0;
            end
          end
        end
      end

      dead_time_pair u_pair (
        .clock         (clock),
        .rst           (rst),
        .ce            (ce),
        .raw           (raw_r[g]),
        .complementary (complementary[g]),
        .dead_time     (dead_time),
        .high_r        (pair_out[2*g]),
        .low_r         (pair_out[2*g+1])
      );
    end
  endgenerate

  // Output stage: debug kill over override over pair
  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : gen_out
      always_ff @(posedge clock) begin
        if (rst) begin
          pwm_out_r[i] <= 1'b0;
        end else if (ce) begin
          if (debug_kill) begin
            pwm_out_r[i] <= 1'b0;
          end else if (override_enable[i]) begin
            pwm_out_r[i] <= override_value[i];
          end else begin
            pwm_out_r[i] <= pair_out[i];
          end
        end
      end
    end
  endgenerate

endmodule

// file: logic/pwm_time_base_pkg.sv
// Shared constants and types for the power-control PWM time base.
// Assumes one clock domain; all users import the whole package.
package pwm_time_base_pkg;

  localparam int CNT_W   = 12;
  localparam int POST_W  = 4;
  localparam int PRE_W   = 6;
  localparam int DT_W    = 6;
  localparam int NUM_GEN = 4;
  localparam int NUM_OUT = 8;

  localparam logic [CNT_W-1:0]  COUNT_RST  = 12'h000;
  localparam logic [CNT_W-1:0]  PERIOD_RST = 12'hFFF;
  localparam logic [CNT_W-1:0]  DUTY_RST   = 12'h000;
  localparam logic [POST_W-1:0] POST_RST   = 4'h0;
  localparam logic [PRE_W-1:0]  PRE_RST    = 6'h00;
  localparam logic [DT_W-1:0]   DT_RST     = 6'h00;

  // Last prescaler count for each ratio
  localparam logic [PRE_W-1:0] PRE_LAST_1  = 6'h00;
  localparam logic [PRE_W-1:0] PRE_LAST_4  = 6'h03;
  localparam logic [PRE_W-1:0] PRE_LAST_16 = 6'h0F;
  localparam logic [PRE_W-1:0] PRE_LAST_64 = 6'h3F;

  typedef enum logic [1:0] {
    MODE_FREE       = 2'b00,
    MODE_SINGLE     = 2'b01,
    MODE_UPDOWN     = 2'b10,
    MODE_UPDOWN_DBL = 2'b11
  } time_base_mode_type;

  typedef enum logic [1:0] {
    PRE_DIV_1  = 2'b00,
    PRE_DIV_4  = 2'b01,
    PRE_DIV_16 = 2'b10,
    PRE_DIV_64 = 2'b11
  } pre_div_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } run_state_type;

endpackage

// file: logic/dead_time_pair.sv
// One output pair with dead-time insertion for complementary drive.
// Assumes raw is a registered duty signal on the same clock.
`timescale 1ns/1ps
module dead_time_pair
  import pwm_time_base_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            raw,
  input  wire logic            complementary,
  input  wire logic [DT_W-1:0] dead_time,
  output logic                 high_r,
  output logic                 low_r
);

  logic            last_r;
  logic [DT_W-1:0] dt_cnt_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      high_r   <= 1'b0;
      low_r    <= 1'b0;
      last_r   <= 1'b0;
      dt_cnt_r <= DT_RST;
    end else if (ce) begin
      if (!complementary) begin
        high_r   <= raw;
        low_r    <= raw;
        last_r   <= raw;
        dt_cnt_r <= DT_RST;
      end else if (raw != last_r) begin
        // Both switches off first, so the bridge never shoots through
        high_r   <= 1'b0;
        low_r    <= 1'b0;
        last_r   <= raw;
        dt_cnt_r <= dead_time;
      end else if (dt_cnt_r != DT_RST) begin
        dt_cnt_r <= dt_cnt_r - 6'h01;
      end else begin
        high_r <= last_r;
        low_r  <= ~last_r;
      end
    end
  end

endmodule

// file: sim/gate_driver_model.sv
// Half-bridge gate driver model: counts cycles with both switches on.
// Assumes both gate inputs are registered on the PWM clock.
`timescale 1ns/1ps
module gate_driver_model (
  input  wire logic clock,
  input  wire logic high_side,
  input  wire logic low_side,
  output int        overlap_count
);
  initial overlap_count = 0;
  // Shoot-through would short the supply, so every such cycle is counted
  always @(posedge clock) begin
    if (high_side === 1'b1 && low_side === 1'b1) begin
      overlap_count++;
    end
  end
endmodule

// file: sim/power_control_pwm_time_base_sva.sv
// Checker for the PWM time base, bound to the top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module power_control_pwm_time_base_sva
  import pwm_time_base_pkg::*;
(
  input wire logic               clock,
  input wire logic               rst,
  input wire logic               ce,
  input wire logic               time_base_enable,
  input wire logic [1:0]         time_base_mode_sel,
  input wire logic [1:0]         time_base_pre_div_sel,
  input wire logic               time_base_control_wr,
  input wire logic               time_base_count_wr,
  input wire logic [CNT_W-1:0]   time_base_count_wdata,
  input wire logic [CNT_W-1:0]   time_base_period,
  input wire logic               debug_mode,
  input wire logic               debug_disable_enable,
  input wire logic [NUM_OUT-1:0] pwm_out_r,
  input wire logic               time_base_irq_r,
  input wire logic [CNT_W-1:0]   time_base_count_r,
  input wire logic               count_direction_flag_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_RESET_CLEAR:
    assert property ($fell(rst) |-> time_base_count_r == 12'h000 && !time_base_irq_r
      && pwm_out_r == 8'h00) else $error("reset did not clear outputs");
  AST_DEBUG_KILL:
    assert property ((ce && debug_mode && debug_disable_enable)[*3] |-> pwm_out_r == 8'h00)
      else $error("outputs active in debug mode");
  AST_COUNT_STEP:
    assert property (time_base_mode_sel == 2'b00 && $past(time_base_mode_sel) == 2'b00
      && !$past(time_base_count_wr) && time_base_count_r != $past(time_base_count_r)
      |-> time_base_count_r == $past(time_base_count_r) + 12'h001
      || time_base_count_r == 12'h000) else $error("free count did not step by one");
  AST_PERIOD_WRAP:
    assert property (time_base_mode_sel == 2'b00 && time_base_pre_div_sel == 2'b00 && ce
      && time_base_enable && $past(time_base_enable) && !time_base_count_wr
      && $stable(time_base_period) && time_base_count_r == time_base_period
      |=> time_base_count_r == 12'h000) else $error("count not zero after match");
  AST_IRQ_AFTER_WRAP:
    assert property (time_base_irq_r && time_base_mode_sel == 2'b00
      |-> time_base_count_r == 12'h000) else $error("irq without period wrap");
  AST_IRQ_PULSE:
    assert property (time_base_irq_r |=> !time_base_irq_r) else $error("irq longer than one cycle");
  AST_WRITE_BLOCKS_IRQ:
    assert property (time_base_control_wr || time_base_count_wr |=> !time_base_irq_r)
      else $error("irq raised after a write");
  AST_COUNT_LOAD:
    assert property (ce && time_base_count_wr |=> time_base_count_r == $past(time_base_count_wdata))
      else $error("count write not loaded");
  AST_DOWN_STEP:
    assert property (time_base_mode_sel[1] && $past(time_base_mode_sel[1])
      && count_direction_flag_r && $past(count_direction_flag_r) && !$past(time_base_count_wr)
      && time_base_count_r != $past(time_base_count_r)
      |-> time_base_count_r == $past(time_base_count_r) - 12'h001) else $error("bad down step");
endmodule
bind power_control_pwm_time_base power_control_pwm_time_base_sva u_sva (
  .clock(clock), .rst(rst), .ce(ce), .time_base_enable(time_base_enable),
  .time_base_mode_sel(time_base_mode_sel), .time_base_pre_div_sel(time_base_pre_div_sel),
  .time_base_control_wr(time_base_control_wr), .time_base_count_wr(time_base_count_wr),
  .time_base_count_wdata(time_base_count_wdata), .time_base_period(time_base_period),
  .debug_mode(debug_mode), .debug_disable_enable(debug_disable_enable),
  .pwm_out_r(pwm_out_r), .time_base_irq_r(time_base_irq_r),
  .time_base_count_r(time_base_count_r), .count_direction_flag_r(count_direction_flag_r));

// file: sim/power_control_pwm_time_base_tb.sv
// Self-checking bench for the PWM time base with gate driver models.
// Assumes inputs change at the falling edge; every test starts from reset.
`timescale 1ns/1ps
module power_control_pwm_time_base_tb;
  import pwm_time_base_pkg::*;
  logic               clock, rst, ce, time_base_enable, time_base_control_wr, time_base_count_wr;
  logic               debug_mode, debug_disable_enable, time_base_irq_r, special_trigger_r;
  logic               count_direction_flag_r, single_pulse_done_r, seen;
  logic [1:0]         time_base_mode_sel, time_base_pre_div_sel;
  logic [POST_W-1:0]  time_base_post_div_sel;
  logic [CNT_W-1:0]   time_base_count_wdata, time_base_period, duty_0, duty_1, duty_2, duty_3;
  logic [CNT_W-1:0]   special_event_compare, time_base_count_r, held;
  logic [NUM_GEN-1:0] complementary;
  logic [DT_W-1:0]    dead_time;
  logic [NUM_OUT-1:0] override_enable, override_value, pwm_out_r;
  int                 errors, check_count, gap, overlap [NUM_GEN];

  power_control_pwm_time_base u_power_control_pwm_time_base (
    .clock(clock), .rst(rst), .ce(ce), .time_base_enable(time_base_enable),
    .time_base_mode_sel(time_base_mode_sel), .time_base_post_div_sel(time_base_post_div_sel),
    .time_base_pre_div_sel(time_base_pre_div_sel), .time_base_control_wr(time_base_control_wr),
    .time_base_count_wr(time_base_count_wr), .time_base_count_wdata(time_base_count_wdata),
    .time_base_period(time_base_period), .duty_0(duty_0), .duty_1(duty_1), .duty_2(duty_2),
    .duty_3(duty_3), .complementary(complementary), .dead_time(dead_time),
    .override_enable(override_enable), .override_value(override_value),
    .special_event_compare(special_event_compare), .debug_mode(debug_mode),
    .debug_disable_enable(debug_disable_enable), .pwm_out_r(pwm_out_r),
    .time_base_irq_r(time_base_irq_r), .special_trigger_r(special_trigger_r),
    .time_base_count_r(time_base_count_r), .count_direction_flag_r(count_direction_flag_r),
    .single_pulse_done_r(single_pulse_done_r));

  for (genvar g = 0; g < NUM_GEN; g++) begin : g_drv
    gate_driver_model u_gate_driver_model (.clock(clock), .high_side(pwm_out_r[2*g]),
      .low_side(pwm_out_r[2*g+1]), .overlap_count(overlap[g]));
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Full reset per test so mode and prescaler never change mid-run
  task automatic start(input logic [1:0] mode, input logic [1:0] pre, input logic [3:0] post,
                       input logic [11:0] per);
    @(negedge clock);
    rst = 1'b1;
    time_base_enable = 1'b0;
    time_base_mode_sel = mode;
    time_base_pre_div_sel = pre;
    time_base_post_div_sel = post;
    time_base_period = per;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    time_base_enable = 1'b1;
  endtask

  task automatic next_irq(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        errors++;
        $display("[ERR] irq wait expected pulse seen none");
        results();
      end
    end while (time_base_irq_r !== 1'b1);
  endtask

  task automatic next_trig(output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n > 2000) begin
        errors++;
        $display("[ERR] trigger wait expected pulse seen none");
        results();
      end
    end while (special_trigger_r !== 1'b1);
  endtask

  task automatic pulse(input bit count_not_control);
    time_base_count_wr = count_not_control;
    time_base_control_wr = !count_not_control;
    @(negedge clock);
    time_base_count_wr = 1'b0;
    time_base_control_wr = 1'b0;
  endtask

  initial begin
    {rst, ce, time_base_enable, time_base_control_wr, time_base_count_wr} = 5'b11000;
    {debug_mode, debug_disable_enable, errors, check_count} = '0;
    {time_base_mode_sel, time_base_pre_div_sel, time_base_post_div_sel} = '0;
    {time_base_count_wdata, duty_1, duty_2, duty_3, special_event_compare} = '0;
    {override_enable, override_value} = '0;
    time_base_period = 12'h002;
    duty_0 = 12'h001;
    complementary = 4'hF;
    dead_time = 6'h02;
    start(2'b00, 2'b00, 4'h0, 12'h002);
    next_irq(gap);
    next_irq(gap);
    check("free gap", 16'h0003, 16'(gap));
    for (int i = 0; i < 3; i++) begin
      check("free count", 16'(i), {4'h0, time_base_count_r});
      @(negedge clock);
    end
    time_base_count_wdata = 12'h001;
    pulse(1'b1);
    check("count load", 16'h0001, {4'h0, time_base_count_r});
    time_base_period = 12'h005;
    next_irq(gap);
    next_irq(gap);
    check("new period gap", 16'h0006, 16'(gap));
    for (int g = 0; g < NUM_GEN; g++) check("overlap", 16'h0000, 16'(overlap[g]));
    check("low side", 16'h0001, {15'h0000, pwm_out_r[3]});
    $display("test free-run done");
    // Prescale 64, post 1:2: 3 ticks per period, 192 cycles per match
    start(2'b00, 2'b11, 4'h1, 12'h002);
    next_irq(gap);
    next_irq(gap);
    check("scaled gap", 16'h0180, 16'(gap));
    repeat (250) @(negedge clock);
    held = time_base_count_r;
    pulse(1'b0);
    check("count kept", {4'h0, held}, {4'h0, time_base_count_r});
    next_irq(gap);
    check("post cleared gap", 16'h0240, 16'(251 + gap));
    $display("test postscaler done");
    start(2'b10, 2'b00, 4'h0, 12'h004);
    next_irq(gap);
    next_irq(gap);
    check("center gap", 16'h0008, 16'(gap));
    seen = 1'b0;
    repeat (8) begin
      @(negedge clock);
      seen = seen | count_direction_flag_r;
    end
    check("down seen", 16'h0001, {15'h0000, seen});
    start(2'b11, 2'b00, 4'h0, 12'h004);
    next_irq(gap);
    next_irq(gap);
    check("dual gap", 16'h0004, 16'(gap));
    $display("test center done");
    // Single pulse: compare 1 fires as the count leaves 1
    special_event_compare = 12'h001;
    start(2'b01, 2'b00, 4'h0, 12'h002);
    next_trig(gap);
    check("trigger count", 16'h0002, {4'h0, time_base_count_r});
    next_irq(gap);
    check("single gap", 16'h0001, 16'(gap));
    repeat (2) @(negedge clock);
    check("single done", 16'h0001, {15'h0000, single_pulse_done_r});
    seen = 1'b0;
    repeat (8) begin
      @(negedge clock);
      seen = seen | time_base_irq_r;
    end
    check("single stopped", 16'h0000, {15'h0000, seen});
    pulse(1'b0);
    repeat (2) @(negedge clock);
    check("single left", 16'h0000, {15'h0000, single_pulse_done_r});
    $display("test single-pulse done");
    duty_0 = 12'h000;
    duty_1 = 12'hFFF;
    complementary = 4'h0;
    start(2'b10, 2'b00, 4'h0, 12'h004);
    repeat (6) @(negedge clock);
    repeat (8) begin
      check("duty limits", 16'h000C, {8'h00, pwm_out_r});
      @(negedge clock);
    end
    override_enable = 8'h01;
    override_value = 8'h01;
    repeat (4) @(negedge clock);
    check("override", 16'h000D, {8'h00, pwm_out_r});
    debug_mode = 1'b1;
    debug_disable_enable = 1'b1;
    repeat (4) @(negedge clock);
    check("debug kill", 16'h0000, {8'h00, pwm_out_r});
    $display("test outputs done");
    results();
  end
endmodule
